// [bridge_secondary_command_reg_bench.sv]
`timescale 1ns/1ps
module bridge_secondary_command_reg_bench;
  import bscr_pkg::*;
  // Bench-driven inputs, all but the clock moved 1 ns after a rising edge
  logic        clock_i = 1'b0;        // 100 MHz core clock
  logic        reset_i = 1'b1;        // Held for the first two edges
  logic        wr      = 1'b0;        // Configuration write strobe
  logic        rd      = 1'b0;        // Configuration read strobe
  logic        rev     = 1'b0;        // Reverse bridge mode
  logic        pcix    = 1'b0;        // Secondary bus in PCI-X mode
  logic [7:0]  addr    = BSCR_OFFSET; // Register byte address
  logic [3:0]  be      = 4'hf;        // Byte enables
  logic [2:0]  cmd     = 3'h0;        // Agent requests: interrupt, fault, parity
  logic [31:0] wdata   = 32'h0;       // Write data
  // Agent and design outputs
  logic        par, flt, irq;         // Agent signals into the register
  logic [31:0] rdata;                 // Read data
  logic        io, mem, mst, spl;     // Decode and master levels
  logic        err, serr, intx, mdpe; // Error, interrupt and flag levels
  int          fails       = 0;       // Mismatches
  int          check_count = 0;       // Comparisons made
  bscr_regs i_bscr_regs (.clock_i(clock_i), .reset_i(reset_i), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
    .reverse_i(rev), .pcix_mode_i(pcix), .parity_event_i(par), .fatal_err_i(flt),
    .intx_req_i(irq), .io_accept_o(io), .mem_rd_accept_o(mem), .master_en_o(mst),
    .split_cpl_en_o(spl), .err_msg_en_o(err), .serr_assert_o(serr), .intx_o(intx),
    .mdpe_o(mdpe));
  bscr_agent i_bscr_agent (.clock_i(clock_i), .cmd_i(cmd), .parity_event_o(par),
    .fatal_err_o(flt), .intx_req_o(irq));
  always #5 clock_i = ~clock_i;
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One configuration access; strobe stands for exactly one edge
  task acc(input logic w, input logic [31:0] d);
    @(posedge clock_i) #1;
    {wr, rd, wdata} = {w, !w, d};
    @(posedge clock_i) #1;
    {wr, rd} = 2'b00;
  endtask
  // Outputs trail the register by a flop, so give them three edges
  task settle;
    repeat (3) @(posedge clock_i) #1;
  endtask
  // Reset leaves every bit and every output low
  task t_reset;
    acc(1'b0, 32'h0);
    check("rdata", rdata, {16'h0, BSCR_RESET});
    check("outs", {io, mem, mst, spl, err, serr, intx, mdpe}, 0);
  endtask
  // Fixed-zero bits must swallow writes of ones; lanes and addresses gate writes
  task t_fields;
    acc(1'b1, 32'h0000_ffff);
    acc(1'b0, 32'h0);
    check("rdata", rdata, 32'h0000_0547);
    settle;
    check("outs", {io, mem, mst, spl, err, serr}, 6'h3e);
    addr = 8'h40;
    acc(1'b0, 32'h0);
    addr = BSCR_OFFSET;
    check("unmapped", rdata, 32'h0);
    // Upper lane alone must leave the lower byte as it was
    be = 4'h2;
    acc(1'b1, 32'h0);
    be = 4'hf;
    acc(1'b0, 32'h0);
    check("lane", rdata, 32'h0000_0047);
    acc(1'b1, 32'h5);
    settle;
    check("outs", {io, mem, mst, spl}, 4'hb);
    acc(1'b1, 32'h3);
    settle;
    check("outs", {io, mem, mst, spl}, 4'h0);
    // A write to another dword must not touch this register
    addr = 8'h40;
    acc(1'b1, 32'h0000_ffff);
    addr = BSCR_OFFSET;
    acc(1'b0, 32'h0);
    check("foreign", rdata, 32'h0000_0003);
  endtask
  // One cycle of parity report from the agent, then time to settle
  task pulse;
    @(posedge clock_i) #1;
    cmd[0] = 1'b1;
    @(posedge clock_i) #1;
    cmd[0] = 1'b0;
    settle;
  endtask
  task t_parity;
    acc(1'b1, 32'h40);
    pulse;
    check("mdpe", mdpe, 1);
    acc(1'b0, 32'h0);
    check("rdata", rdata, 32'h0100_0040);
    be = 4'h8;
    acc(1'b1, 32'h0100_0000);
    be = 4'hf;
    settle;
    acc(1'b0, 32'h0);
    check("rdata", rdata, 32'h0000_0040);
    acc(1'b1, 32'h0);
    pulse;
    check("mdpe", mdpe, 0);
  endtask
  task t_intx;
    cmd = 3'h4;
    acc(1'b1, 32'h0);
    settle;
    check("intx", intx, 1);
    acc(1'b1, 32'h400);
    settle;
    check("intx", intx, 0);
    cmd = 3'h0;
  endtask
  // Reverse PCI-X completes splits even with mastering off; mode steers errors
  task t_rev;
    {rev, pcix} = 2'b11;
    cmd = 3'h2;
    acc(1'b1, 32'h100);
    settle;
    check("rev", {spl, err, serr}, 3'h5);
    pcix = 1'b0;
    settle;
    check("rev_pci", {spl, err, serr}, 3'h1);
    rev = 1'b0;
    settle;
    check("fwd", {spl, err, serr}, 3'h2);
    rev = 1'b1;
    acc(1'b1, 32'h0);
    settle;
    check("rev_off", {spl, err, serr}, 3'h0);
    rev = 1'b0;
    cmd = 3'h0;
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clock_i) #1;
    reset_i = 1'b0;
    t_reset;
    t_fields;
    t_parity;
    t_intx;
    t_rev;
    report_and_stop;
  end
  // Whole run is under a hundred cycles; the watchdog allows ten thousand
  initial
  begin
    #100000 fails++;
    report_and_stop;
  end
endmodule // bridge_secondary_command_reg_bench

// [bscr_agent.sv]
`timescale 1ns/1ps
// Secondary bus agent: reports parity trouble, faults and interrupt wishes
module bscr_agent (
  input  wire logic       clock_i,        // Core clock
  input  wire logic [2:0] cmd_i,          // Parity, fault, interrupt
  output logic            parity_event_o, // Parity report, one flop late
  output logic            fatal_err_o,    // Held fault
  output logic            intx_req_o      // Held interrupt wish
);
  // Registered so the report lands off the bench's own edge
  always_ff @(posedge clock_i)
  begin
    parity_event_o <= cmd_i[0];
  end
  assign fatal_err_o = cmd_i[1];
  assign intx_req_o  = cmd_i[2];
endmodule // bscr_agent

// [bscr_pkg.sv]
package bscr_pkg;
  // Register location in configuration space (byte address, dword-aligned)
  localparam logic [7:0]  BSCR_OFFSET          = 8'h44;
  localparam logic [15:0] BSCR_RESET           = 16'h0000;
  // Field positions of the command half
  localparam int          BSCR_IO_EN_BIT       = 0;
  localparam int          BSCR_MEM_EN_BIT      = 1;
  localparam int          BSCR_MASTER_EN_BIT   = 2;
  localparam int          BSCR_SPECIAL_BIT     = 3;
  localparam int          BSCR_MWI_BIT         = 4;
  localparam int          BSCR_PALETTE_BIT     = 5;
  localparam int          BSCR_PERR_RESP_BIT   = 6;
  localparam int          BSCR_WAIT_BIT        = 7;
  localparam int          BSCR_SERR_EN_BIT     = 8;
  localparam int          BSCR_FBB_BIT         = 9;
  localparam int          BSCR_INTX_DIS_BIT    = 10;
  // Writable bits of the command half; everything else reads zero
  localparam logic [15:0] BSCR_RW_MASK         = 16'h0547;
  // Status half: master data parity error flag sits at bit 24 of the dword
  localparam int          BSCR_MDPE_BIT        = 24;
endpackage : bscr_pkg

// [bscr_regs.sv]
`timescale 1ns/1ps
// How it works
// [RULE1] Bit 0 clear ignores secondary I/O
// [RULE2] Bit 1 clear ignores secondary memory reads
// [RULE3] Bit 2 clear blocks mastering and responding
// [RULE4] Split completions allowed regardless in reverse PCI-X
// [RULE5] Bit 3 reads zero, no special cycles
// [RULE6] Bit 4 reads zero, MWI only forwarded
// [RULE7] Bit 5 reads zero, palette snoop ignored
// [RULE8] Bit 6 set: parity events set flag
// [RULE9] Bit 6 clear: parity events ignored
// [RULE10] Bit 7 wait cycle control reads zero
// [RULE11] Forward mode: bit 8 gates error messages
// [RULE12] Reverse mode: bit 8 gates system error
// [RULE13] Bit 9 fast back-to-back reads zero
// [RULE14] Bit 10 set stops and releases INTx
// [RULE15] Bits 15 to 11 reserved, read zero
// [RULE16] Parity flag needs enable, write-one clears
// [RULE17] Writes to read-only bits are ignored
module bscr_regs
  import bscr_pkg::*;
(
  input  wire logic        clock_i,         // Bridge core clock
  input  wire logic        reset_i,         // Asynchronous, active high
  input  wire logic        cfg_wr_i,        // Configuration write strobe
  input  wire logic        cfg_rd_i,        // Configuration read strobe
  input  wire logic [7:0]  cfg_addr_i,      // Configuration byte address
  input  wire logic [3:0]  cfg_be_i,        // Byte enables of the dword
  input  wire logic [31:0] cfg_wdata_i,     // Write data
  output logic      [31:0] cfg_rdata_o,     // Registered read data
  input  wire logic        reverse_i,       // Bridge runs in reverse mode
  input  wire logic        pcix_mode_i,     // Secondary bus runs PCI-X
  input  wire logic        parity_event_i,  // Poisoned TLP or parity error seen
  input  wire logic        fatal_err_i,     // Error condition to report
  input  wire logic        intx_req_i,      // Interrupt request from the core
  output logic             io_accept_o,     // May answer secondary I/O
  output logic             mem_rd_accept_o, // May answer secondary memory reads
  output logic             master_en_o,     // May master memory/I-O on secondary
  output logic             split_cpl_en_o,  // May issue split completions
  output logic             err_msg_en_o,    // Forward: may send error messages
  output logic             serr_assert_o,   // Reverse: drive system error
  output logic             intx_o,          // INTx message assertion level
  output logic             mdpe_o           // Master data parity error flag
);

  logic [15:0] cmd_q, cmd_d;       // Command half, only writable bits stored
  logic        mdpe_q, mdpe_d;     // Sticky parity flag
  logic [31:0] rdata_q, rdata_d;   // Read data register
  logic [6:0]  ctl_q, ctl_d;       // Registered control outputs, one per level
  logic        hit;                // Access targets this dword

  // Whole byte address is compared, so only the dword's base address hits
  assign hit = (cfg_addr_i == BSCR_OFFSET);

  // Next-state logic for the command bits and the sticky flag
  always_comb
  begin
    cmd_d  = cmd_q;
    mdpe_d = mdpe_q;
    if (cfg_wr_i && hit)
    begin
      // Only writable bits land; read-only and reserved bits stay zero
      if (cfg_be_i[0])
        cmd_d[7:0] = cfg_wdata_i[7:0] & BSCR_RW_MASK[7:0];        // [RULE17] [RULE5] [RULE6]
      if (cfg_be_i[1])
        cmd_d[15:8] = cfg_wdata_i[15:8] & BSCR_RW_MASK[15:8];     // [RULE15] [RULE13]
      if (cfg_be_i[3] && cfg_wdata_i[BSCR_MDPE_BIT])
        mdpe_d = 1'b0;                                            // [RULE16]
    end
    // Set beats a simultaneous clear, so no event is lost
    if (parity_event_i && cmd_q[BSCR_PERR_RESP_BIT])
      mdpe_d = 1'b1;                                              // [RULE8] [RULE9] [RULE16]
  end

  // Read data and control outputs, all from flip-flops
  always_comb
  begin
    rdata_d = rdata_q;
    if (cfg_rd_i)
    begin
      rdata_d = 32'h0000_0000;
      if (hit)
      begin
        rdata_d[15:0]          = cmd_q & BSCR_RW_MASK;            // [RULE10] [RULE7]
        rdata_d[BSCR_MDPE_BIT] = mdpe_q;
      end
    end
    ctl_d[0] = cmd_q[BSCR_IO_EN_BIT] & cmd_q[BSCR_MASTER_EN_BIT];  // [RULE1] [RULE3]
    ctl_d[1] = cmd_q[BSCR_MEM_EN_BIT] & cmd_q[BSCR_MASTER_EN_BIT]; // [RULE2] [RULE3]
    ctl_d[2] = cmd_q[BSCR_MASTER_EN_BIT];                          // [RULE3] [RULE4]
    // Reverse PCI-X split completions ignore the master enable
    ctl_d[3] = cmd_q[BSCR_MASTER_EN_BIT] | (reverse_i & pcix_mode_i); // [RULE4]
    ctl_d[4] = ~reverse_i & cmd_q[BSCR_SERR_EN_BIT];               // [RULE11]
    ctl_d[5] = reverse_i & cmd_q[BSCR_SERR_EN_BIT] & fatal_err_i;  // [RULE12]
    // Disable drops any asserted INTx on the next edge
    ctl_d[6] = intx_req_i & ~cmd_q[BSCR_INTX_DIS_BIT];             // [RULE14]
  end

  // Command bits and the sticky flag
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmd_q  <= BSCR_RESET;   // All command bits come up cleared
      mdpe_q <= 1'b0;         // No parity trouble seen yet
    end
    else
    begin
      cmd_q  <= cmd_d;
      mdpe_q <= mdpe_d;
    end
  end

  // Read data and control levels; the extra flop costs a cycle of delay
  // on every enable but keeps the outputs clean of decode glitches
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rdata_q <= 32'h0000_0000; // Reads before the first access return zero
      ctl_q   <= 7'h00;         // Everything disabled
    end
    else
    begin
      rdata_q <= rdata_d;
      ctl_q   <= ctl_d;
    end
  end

  // Every output is a flop's own output; no gate sits behind it
  assign cfg_rdata_o     = rdata_q;
  assign io_accept_o     = ctl_q[0];
  assign mem_rd_accept_o = ctl_q[1];
  assign master_en_o     = ctl_q[2];
  assign split_cpl_en_o  = ctl_q[3];
  assign err_msg_en_o    = ctl_q[4];
  assign serr_assert_o   = ctl_q[5];
  assign intx_o          = ctl_q[6];
  assign mdpe_o          = mdpe_q;

  // Assertions. They are off while reset is held; at the first edge after
  // release, $past and $rose see the reset values, which are all zero.

  // Read-only and reserved bits never hold a one
  AST_RO_ZERO: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE17]
    (cmd_q & ~BSCR_RW_MASK) == 16'h0000) else $error("read-only bit set");

  // The flag only rises after an enabled parity event
  AST_MDPE_NEEDS_EN: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE16]
    $rose(mdpe_q) |-> $past(cmd_q[BSCR_PERR_RESP_BIT]) && $past(parity_event_i))
    else $error("parity flag set without enable");

  // An enabled parity event always lands in the flag
  AST_MDPE_SET: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE8]
    parity_event_i && cmd_q[BSCR_PERR_RESP_BIT] |=> mdpe_q) else $error("parity flag missed");

  // With the response enable off the flag can never come up
  AST_MDPE_QUIET: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE9]
    !cmd_q[BSCR_PERR_RESP_BIT] && !mdpe_q |=> !mdpe_q)
    else $error("parity flag set while disabled");

  // Write of one to the flag with no competing event in the same cycle
  sequence seq_flag_clear;
    cfg_wr_i && hit && cfg_be_i[3] && cfg_wdata_i[BSCR_MDPE_BIT] &&
    !(parity_event_i && cmd_q[BSCR_PERR_RESP_BIT]);
  endsequence

  // The clear takes effect at the very next edge
  AST_MDPE_CLEAR: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE16]
    seq_flag_clear |=> !mdpe_q) else $error("parity flag not cleared");

  // Disable drops INTx within one edge
  AST_INTX_OFF: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE14]
    cmd_q[BSCR_INTX_DIS_BIT] |=> !intx_o) else $error("intx not released");

  // While enabled, a request shows on INTx one edge later
  AST_INTX_ON: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE14]
    intx_req_i && !cmd_q[BSCR_INTX_DIS_BIT] |=> intx_o) else $error("intx not raised");

  // I/O decoding off means no I/O response
  AST_IO_GATE: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE1]
    !cmd_q[BSCR_IO_EN_BIT] |=> !io_accept_o) else $error("io accepted while disabled");

  // Memory decoding off means no memory read response
  AST_MEM_GATE: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE2]
    !cmd_q[BSCR_MEM_EN_BIT] |=> !mem_rd_accept_o) else $error("mem read accepted");

  // Master enable off stops both mastering and I/O responding
  AST_MASTER_GATE: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE3]
    !cmd_q[BSCR_MASTER_EN_BIT] |=> !master_en_o && !io_accept_o) else $error("master active");

  // Low byte write that sets the master enable
  sequence seq_master_write;
    cfg_wr_i && hit && cfg_be_i[0] && cfg_wdata_i[BSCR_MASTER_EN_BIT];
  endsequence

  // Register takes it at the next edge, the output flop one edge later
  sequence seq_master_on;
    ##1 cmd_q[BSCR_MASTER_EN_BIT] ##1 master_en_o;
  endsequence

  // A write of the master enable reaches the output two edges later
  AST_MASTER_WRITE: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE3]
    seq_master_write |-> seq_master_on) else $error("master enable write lost");

  // Reverse PCI-X completes splits whatever the master enable says
  AST_SPLIT: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE4]
    reverse_i && pcix_mode_i |=> split_cpl_en_o) else $error("split completion blocked");

  // Outside that case splits follow the master enable
  AST_SPLIT_MASTER: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE4]
    !cmd_q[BSCR_MASTER_EN_BIT] && !(reverse_i && pcix_mode_i) |=> !split_cpl_en_o)
    else $error("split completion while mastering is off");

  // System error only in reverse mode with the enable set
  AST_SERR: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE12]
    serr_assert_o |-> $past(reverse_i) && $past(cmd_q[BSCR_SERR_EN_BIT])) else $error("serr");

  // With the enable clear neither error path is open
  AST_SERR_OFF: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE12]
    !cmd_q[BSCR_SERR_EN_BIT] |=> !serr_assert_o && !err_msg_en_o)
    else $error("error path open while disabled");

  // Error messages only in forward mode
  AST_ERRMSG: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE11]
    err_msg_en_o |-> !$past(reverse_i)) else $error("error message in reverse");

  // Read of this dword
  sequence seq_read_hit;
    cfg_rd_i && hit;
  endsequence

  // Read data shows the stored command bits one edge later
  AST_READ_BACK: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE17]
    seq_read_hit |=> cfg_rdata_o[15:0] == $past(cmd_q)) else $error("read data wrong");

  // A read of any other dword answers zero
  AST_READ_MISS: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE17]
    cfg_rd_i && !hit |=> cfg_rdata_o == 32'h0000_0000) else $error("unmapped read not zero");

endmodule // bscr_regs
